// ### logic/cursor_position_color_regs.v
//
// What this block does
// - Row register pair per panel and CRT
// - Rows from -1023 to 1023 accepted
// - Sign-magnitude: ten-bit magnitude, sign flag
// - High byte: sign bit7, magnitude bits1-0
// - New position applied on high-byte write
// - Panel colour 0 blue, five bits
// - Panel colour 0 green, six bits
// - Colour 0 forms 5-6-5 value
// - Overlay mode select; cursor 64x64
`timescale 1ns/1ps
`default_nettype none
`include "cursor_regs_consts.vh"

module cursor_position_color_regs #(
	parameter ADDR_W = 12
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg [1:0] panel_overlay_mode,
	output reg [1:0] crt_overlay_mode,
	output reg panel_cursor_on,
	output reg crt_cursor_on,
	output reg [6:0] cursor_edge,
	output reg panel_row_sign,
	output reg [9:0] panel_row_mag,
	output reg crt_row_sign,
	output reg [9:0] crt_row_mag,
	output reg [15:0] panel_color0_565
);

	// Word index match with aligned byte address
	function hit;
		input [ADDR_W-1:0] addr;
		input [9:0] idx;
		begin
			hit = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]);
		end
	endfunction

	// Readback byte of an applied row: sign, zero gap, top magnitude bits
	function [7:0] shown_byte;
		input sign;
		input [9:0] mag;
		begin
			shown_byte = {sign, 5'h00, mag[9:8]};
		end
	endfunction

	// APB phase qualifiers
	wire access = psel & penable & ~pready;
	wire wr_en = psel & penable & pready & pwrite;

	// Register selects, shared by read and write decode
	wire sel_panel_mode = hit(paddr, `IDX_PANEL_MODE);
	wire sel_crt_mode = hit(paddr, `IDX_CRT_MODE);
	wire sel_panel_row_low = hit(paddr, `IDX_PANEL_ROW_LOW);
	wire sel_panel_row_high = hit(paddr, `IDX_PANEL_ROW_HIGH);
	wire sel_crt_row_low = hit(paddr, `IDX_CRT_ROW_LOW);
	wire sel_crt_row_high = hit(paddr, `IDX_CRT_ROW_HIGH);
	wire sel_blue0 = hit(paddr, `IDX_PANEL_BLUE0);
	wire sel_green0 = hit(paddr, `IDX_PANEL_GREEN0);
	wire sel_panel_shown = hit(paddr, `IDX_PANEL_ROW_SHOWN);
	wire sel_crt_shown = hit(paddr, `IDX_CRT_ROW_SHOWN);

	// Write strobes, taken at the edge that sees pready high
	wire wr_blue0 = wr_en & sel_blue0;
	wire wr_green0 = wr_en & sel_green0;
	wire wr_panel_mode = wr_en & sel_panel_mode;
	wire wr_crt_mode = wr_en & sel_crt_mode;
	wire [1:0] wr_row_low = {2{wr_en}} & {sel_crt_row_low, sel_panel_row_low}; // Index 0 is panel
	wire [1:0] wr_row_high = {2{wr_en}} & {sel_crt_row_high, sel_panel_row_high};
	reg [7:0] blue0;
	reg [7:0] green0;
	reg [7:0] next_rdata;
	reg mapped;
	wire [7:0] row_low [0:1];
	wire [7:0] row_high [0:1];
	wire shown_sign [0:1];
	wire [9:0] shown_mag [0:1];

	// One row latch per display path
	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1) begin : path
			cursor_row_latch u_row (
				.pclk(pclk),
				.presetn(presetn),
				.wr_low(wr_row_low[p]),
				.wr_high(wr_row_high[p]), // Only this one moves the shown row
				.wdata(pwdata[7:0]),
				.row_low(row_low[p]),
				.row_high(row_high[p]),
				.shown_sign(shown_sign[p]),
				.shown_mag(shown_mag[p])
			);
		end
	endgenerate

	// Read decode; unused bits come back zero
	always @* begin
		next_rdata = `RESET_BYTE;
		mapped = 1'b1;
		if (sel_panel_mode) begin
			next_rdata = {6'h00, panel_overlay_mode};
		end else if (sel_crt_mode) begin
			next_rdata = {6'h00, crt_overlay_mode};
		end else if (sel_panel_row_low) begin
			next_rdata = row_low[0];
		end else if (sel_panel_row_high) begin
			next_rdata = row_high[0];
		end else if (sel_crt_row_low) begin
			next_rdata = row_low[1];
		end else if (sel_crt_row_high) begin
			next_rdata = row_high[1];
		end else if (sel_blue0) begin
			next_rdata = blue0;
		end else if (sel_green0) begin
			next_rdata = green0;
		end else if (sel_panel_shown) begin
			next_rdata = shown_byte(shown_sign[0], shown_mag[0]);
		end else if (sel_crt_shown) begin
			next_rdata = shown_byte(shown_sign[1], shown_mag[1]);
		end else begin
			mapped = 1'b0;
		end
	end

	// APB answer: one wait state, then ready with or without error
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= access;
			pslverr <= access & ~mapped;
		end
	end

	// Read data, held until the next read
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `RESET_WORD;
		end else if (access && !pwrite) begin
			prdata <= {24'h000000, next_rdata};
		end
	end

	// Colour 0 components; unused bits are masked on write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blue0 <= `RESET_BYTE;
			green0 <= `RESET_BYTE;
		end else begin
			if (wr_blue0) begin
				blue0 <= pwdata[7:0] & `BLUE_MASK;
			end
			if (wr_green0) begin
				green0 <= pwdata[7:0] & `GREEN_MASK;
			end
		end
	end

	// Overlay mode per display path
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel_overlay_mode <= `MODE_INACTIVE;
			crt_overlay_mode <= `MODE_INACTIVE;
		end else begin
			if (wr_panel_mode) begin
				panel_overlay_mode <= pwdata[`MODE_W-1:0];
			end
			if (wr_crt_mode) begin
				crt_overlay_mode <= pwdata[`MODE_W-1:0];
			end
		end
	end

	// Mode flags and cursor size toward the display paths
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel_cursor_on <= 1'b0;
			crt_cursor_on <= 1'b0;
			cursor_edge <= `RESET_EDGE;
		end else begin
			panel_cursor_on <= (panel_overlay_mode == `MODE_CURSOR);
			crt_cursor_on <= (crt_overlay_mode == `MODE_CURSOR);
			cursor_edge <= `CURSOR_EDGE;
		end
	end

	// Applied rows, one cycle behind the row latches
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel_row_sign <= 1'b0;
			panel_row_mag <= `RESET_MAG;
			crt_row_sign <= 1'b0;
			crt_row_mag <= `RESET_MAG;
		end else begin
			panel_row_sign <= shown_sign[0];
			panel_row_mag <= shown_mag[0];
			crt_row_sign <= shown_sign[1];
			crt_row_mag <= shown_mag[1];
		end
	end

	// Colour 0 as a 5-6-5 word; red field lives elsewhere and stays zero
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel_color0_565 <= `RESET_565;
		end else begin
			panel_color0_565 <= {5'h00, green0[`GREEN_W-1:0], blue0[`BLUE_W-1:0]};
		end
	end

endmodule // cursor_position_color_regs

`default_nettype wire

// ### logic/cursor_regs_consts.vh
`ifndef CURSOR_REGS_CONSTS_VH
`define CURSOR_REGS_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_PANEL_MODE 10'h070
`define IDX_PANEL_ROW_LOW 10'h074
`define IDX_PANEL_ROW_HIGH 10'h075
`define IDX_PANEL_BLUE0 10'h076
`define IDX_PANEL_GREEN0 10'h077
`define IDX_CRT_MODE 10'h080
`define IDX_CRT_ROW_LOW 10'h084
`define IDX_CRT_ROW_HIGH 10'h085
`define IDX_PANEL_ROW_SHOWN 10'h0f0
`define IDX_CRT_ROW_SHOWN 10'h0f1

// Field layout of the high row register
`define ROW_SIGN_BIT 7
`define ROW_MAG_HI_MSB 1
`define ROW_HIGH_MASK 8'h83

// Colour field widths and masks
`define BLUE_W 5
`define GREEN_W 6
`define BLUE_MASK 8'h1f
`define GREEN_MASK 8'h3f

// Overlay mode field
`define MODE_W 2
`define MODE_MASK 8'h03
`define MODE_INACTIVE 2'h0
`define MODE_CURSOR 2'h1
`define MODE_INK 2'h2
`define MODE_RESERVED 2'h3

// Cursor image edge in pixels
`define CURSOR_EDGE 7'h40

// Reset values
`define RESET_BYTE 8'h00
`define RESET_WORD 32'h00000000
`define RESET_MAG 10'h000
`define RESET_EDGE 7'h00
`define RESET_565 16'h0000

`endif

// ### logic/cursor_row_latch.v
`timescale 1ns/1ps
`default_nettype none
`include "cursor_regs_consts.vh"

module cursor_row_latch (
	input wire pclk,
	input wire presetn,
	input wire wr_low,
	input wire wr_high,
	input wire [7:0] wdata,
	output reg [7:0] row_low,
	output reg [7:0] row_high,
	output reg shown_sign,
	output reg [9:0] shown_mag
);

	// Staged bytes, and the row the display actually uses
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			row_low <= `RESET_BYTE;
			row_high <= `RESET_BYTE;
			shown_sign <= 1'b0;
			shown_mag <= `RESET_MAG;
		end else begin
			if (wr_low) begin
				row_low <= wdata; // Held, not shown yet
			end
			if (wr_high) begin
				row_high <= wdata & `ROW_HIGH_MASK; // Unused bits dropped
				shown_sign <= wdata[`ROW_SIGN_BIT]; // Sign flag
				shown_mag <= {wdata[`ROW_MAG_HI_MSB:0], row_low}; // Applied together
			end
		end
	end

endmodule // cursor_row_latch

`default_nettype wire

// ### verif/cursor_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cursor_regs_checker (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire crt_row_sign,
	input wire [9:0] crt_row_mag,
	input wire [9:0] panel_row_mag,
	input wire [15:0] panel_color0_565
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Accepted write and read strobes
	wire wr = pready && pwrite && !pslverr;
	wire rd = pready && !pwrite && !pslverr;
	chk_one_wait:
		assert property (psel && penable && !pready |=> pready) else $error("late answer");
	chk_err_unaligned:
		assert property (pready && paddr[1:0] != 0 |-> pslverr) else $error("unaligned taken");
	chk_high_bits:
		assert property (rd && paddr == 12'h214 |-> prdata[31:8] == 0 && prdata[6:2] == 0)
		else $error("high row unused bits");
	chk_blue_bits:
		assert property (rd && paddr == 12'h1d8 |-> prdata[31:5] == 0) else $error("blue bits");
	chk_green_bits:
		assert property (rd && paddr == 12'h1dc |-> prdata[31:6] == 0) else $error("green bits");
	chk_crt_apply:
		assert property (wr && paddr == 12'h214 |-> ##2 crt_row_sign == $past(pwdata[7], 2)
		&& crt_row_mag[9:8] == $past(pwdata[1:0], 2)) else $error("row not applied");
	chk_crt_hold:
		assert property (!$stable(crt_row_mag) |-> $past(wr && paddr == 12'h214, 2))
		else $error("crt row moved");
	chk_panel_hold:
		assert property (!$stable(panel_row_mag) |-> $past(wr && paddr == 12'h1d4, 2))
		else $error("panel row moved");
	chk_blue_565:
		assert property (wr && paddr == 12'h1d8 |-> ##2
		panel_color0_565[4:0] == $past(pwdata[4:0], 2)) else $error("blue field");
endmodule // cursor_regs_checker
bind cursor_position_color_regs cursor_regs_checker u_cursor_regs_checker (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .crt_row_sign,
	.crt_row_mag, .panel_row_mag, .panel_color0_565);
`default_nettype wire

// ### verif/test_cursor_position_color_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_cursor_position_color_regs;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic pready, pslverr, ps, pon, cs, con;
	logic [1:0] pm, cm;
	logic [6:0] edge_px;
	logic [9:0] pmag, cmag;
	logic [15:0] c565;
	logic [7:0] lo [2] = '{8'h3f, 8'hff};
	logic [7:0] hi [2] = '{8'hfc, 8'h03};
	integer failures = 0, n_tests = 0, k;
	cursor_position_color_regs u_cursor_position_color_regs (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .panel_overlay_mode(pm),
		.crt_overlay_mode(cm), .panel_cursor_on(pon), .crt_cursor_on(con), .cursor_edge(edge_px),
		.panel_row_sign(ps), .panel_row_mag(pmag), .crt_row_sign(cs), .crt_row_mag(cmag),
		.panel_color0_565(c565));
	always #5 pclk = ~pclk;
	task results;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input [31:0] s, input [31:0] x);
		n_tests++;
		if (s !== x) begin
			failures++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
		end
	endtask
	// One APB transfer, bounded wait for pready
	task acc(input w, input [11:0] a, input [31:0] d);
		integer i;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin
			failures++;
			results();
		end
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task rdc(input [11:0] a, input [31:0] x);
		acc(0, a, 0);
		chk(r, x);
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		repeat (2) @(posedge pclk);
		chk(edge_px, 7'h40);
		rdc(12'h214, 0);
		// Colour 0 fields and unused bits
		acc(1, 12'h1d8, 32'hff);
		acc(1, 12'h1dc, 32'hff);
		rdc(12'h1d8, 32'h1f);
		rdc(12'h1dc, 32'h3f);
		chk(c565, 16'h07ff);
		$display("colour test done");
		// Rows -63 and 1023, held until high write
		for (k = 0; k < 2; k++) begin
			acc(1, 12'h210, lo[k]);
			chk(cmag, k ? 10'h03f : 10'h000);
			acc(1, 12'h214, hi[k]);
			rdc(12'h214, hi[k] & 8'h83);
			rdc(12'h3c4, hi[k] & 8'h83);
			chk(cmag, {hi[k][1:0], lo[k]});
			chk(cs, hi[k][7]);
		end
		acc(1, 12'h1d0, 32'h2a);
		acc(1, 12'h1d4, 32'h01);
		rdc(12'h1d0, 32'h2a);
		rdc(12'h3c0, 32'h01);
		chk({ps, pmag}, 11'h12a);
		$display("row test done");
		// Refused addresses
		acc(0, 12'h1d9, 0);
		chk(e, 1);
		chk(r, 0);
		acc(1, 12'h000, 32'hff);
		chk(e, 1);
		$display("refused test done");
		// Every overlay mode, the CRT path set to the inverse code
		for (k = 0; k < 4; k++) begin
			acc(1, 12'h1c0, k);
			acc(1, 12'h200, 3 - k);
			rdc(12'h1c0, k);
			rdc(12'h200, 3 - k);
			chk({pm, pon}, {k[1:0], k == 1});
			chk({cm, con}, {~k[1:0], k == 2});
			if (k == 2) begin
				acc(1, 12'h1d0, 0);
				acc(1, 12'h1d4, 0);
				@(posedge pclk);
				chk({ps, pmag}, 11'h000);
			end
		end
		$display("mode test done");
		results();
	end
endmodule // test_cursor_position_color_regs
`default_nettype wire
